// ### verilog/i2c_collision_pkg.sv
// Functional notes
// - Repeated start: SDA low when SCL rises flags a collision.
// - Repeated start: SCL falling before we pull SDA low flags a collision.
// - Repeated start: release SDA, when high count reload value, then release SCL.
// - Repeated start: SCL sampled high, then SDA low at expiry returns to idle with no collision.
// - SDA high: reload and count again; SDA falling then is no collision.
// - Second count: SCL falling before expiry with SDA undriven flags collision.
// - Both lines high at expiry: drive SDA low, reload, count again.
// - Final count ends: drive SCL low regardless, repeated start done.
// - Stop: SDA sampled low after released and count expired flags collision.
// - Stop: SCL falling after released SCL was sampled high, before SDA high, flags collision.
// - Stop: drive SDA low, release SCL, on SCL high count, then sample SDA.
// - Any collision sets the collision flag and returns to idle.
// - Collision aborts the condition, releases both lines, clears sequence bits.
// - Counter suspended while released SCL is low, reloads once SCL high.
package i2c_collision_pkg;

	localparam int RELOAD_WIDTH = 7;

	typedef enum logic [1:0] {
		SEQ_NONE,
		SEQ_RESTART,
		SEQ_STOP
	} seq_kind_t;

	// Sequence control bits: repeated start and stop enables
	typedef struct packed {
		logic restart_enable;
		logic stop_enable;
	} master_sequence_control_t;

	typedef struct packed {
		logic sda;
		logic scl;
	} bus_lines_t;

	localparam logic [RELOAD_WIDTH-1:0] COUNT_ZERO = 7'h00;
	localparam logic [RELOAD_WIDTH-1:0] COUNT_STEP = 7'h01;

endpackage

// ### verilog/i2c_master_collision_detect.sv
`timescale 1ns/1ns
module i2c_master_collision_detect (
	input  wire logic                                        i_clock,
	input  wire logic                                        i_rst,
	input  wire logic [i2c_collision_pkg::RELOAD_WIDTH-1:0]  i_bit_rate_reload_value,
	input  wire i2c_collision_pkg::master_sequence_control_t i_master_sequence_control,
	input  wire logic                                        i_clear_bus_collision_flag,
	input  wire i2c_collision_pkg::bus_lines_t               i_bus,
	output logic                                             o_sda_oe,
	output logic                                             o_scl_oe,
	output logic                                             o_sda,
	output logic                                             o_scl,
	output i2c_collision_pkg::master_sequence_control_t      o_master_sequence_control,
	output logic                                             o_bus_collision_flag,
	output logic                                             o_busy,
	output logic                                             o_done
);

	typedef enum logic [3:0] {
		ST_IDLE,
		RS_SDA_WAIT,
		RS_COUNT1,
		RS_SCL_WAIT,
		RS_COUNT2,
		RS_COUNT3,
		SP_SDA_WAIT,
		SP_SCL_WAIT,
		SP_COUNT1,
		SP_COUNT2
	} state_t;

	state_t                                  state;
	logic [i2c_collision_pkg::RELOAD_WIDTH-1:0] bit_rate_counter;
	logic                                    sda_low;
	logic                                    scl_low;
	logic                                    scl_prev;
	logic                                    collision;
	logic                                    count_done;
	logic                                    load;

	assign count_done = (bit_rate_counter == i2c_collision_pkg::COUNT_ZERO);

	// ============================================================
	// Collision detection
	always_comb begin
		collision = 1'b0;
		case (state)
			RS_SCL_WAIT:
				if (i_bus.scl && !scl_prev && !i_bus.sda)
					collision = 1'b1;
			RS_COUNT2:
				if (!i_bus.scl && scl_prev)
					collision = 1'b1;
			SP_SCL_WAIT:
				collision = 1'b0;
			SP_COUNT1:
				if (scl_prev && !i_bus.scl)
					collision = 1'b1;
			SP_COUNT2:
				if (count_done && !i_bus.sda)
					collision = 1'b1;
				else if (!i_bus.scl && !i_bus.sda)
					collision = 1'b1;
			default:
				collision = 1'b0;
		endcase
	end

	// Counter reload points
	always_comb begin
		load = 1'b0;
		case (state)
			RS_SDA_WAIT:
				load = i_bus.sda;
			RS_SCL_WAIT:
				load = i_bus.scl && i_bus.sda;
			RS_COUNT2:
				load = count_done && i_bus.scl && i_bus.sda;
			SP_SCL_WAIT:
				load = i_bus.scl;
			SP_COUNT1:
				load = count_done;
			default:
				load = 1'b0;
		endcase
	end

	// ============================================================
	// Bit rate counter
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			bit_rate_counter <= i2c_collision_pkg::COUNT_ZERO;
		end else if (load) begin
			bit_rate_counter <= i_bit_rate_reload_value;
		end else if (!count_done) begin
			bit_rate_counter <= bit_rate_counter - i2c_collision_pkg::COUNT_STEP;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			scl_prev <= 1'b1;
		end else begin
			scl_prev <= i_bus.scl;
		end
	end

	// ============================================================
	// Sequence state machine
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
		end else if (collision) begin
			state <= ST_IDLE;
			sda_low <= 1'b0;
			scl_low <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (i_master_sequence_control.restart_enable) begin
						state <= RS_SDA_WAIT;
						sda_low <= 1'b0;
						scl_low <= 1'b1;
					end else if (i_master_sequence_control.stop_enable) begin
						state <= SP_SDA_WAIT;
						sda_low <= 1'b1;
						scl_low <= 1'b1;
					end
				end
				RS_SDA_WAIT:
					if (i_bus.sda)
						state <= RS_COUNT1;
				RS_COUNT1:
					if (count_done) begin
						scl_low <= 1'b0;
						state <= RS_SCL_WAIT;
					end
				RS_SCL_WAIT:
					if (i_bus.scl)
						state <= RS_COUNT2;
				RS_COUNT2:
					if (count_done && i_bus.scl && i_bus.sda) begin
						sda_low <= 1'b1;
						state <= RS_COUNT3;
					end else if (count_done) begin
						state <= ST_IDLE;
						sda_low <= 1'b0;
						scl_low <= 1'b0;
					end
				RS_COUNT3:
					if (count_done) begin
						scl_low <= 1'b1;
						state <= ST_IDLE;
					end
				SP_SDA_WAIT:
					if (!i_bus.sda) begin
						scl_low <= 1'b0;
						state <= SP_SCL_WAIT;
					end
				SP_SCL_WAIT:
					if (i_bus.scl)
						state <= SP_COUNT1;
				SP_COUNT1:
					if (count_done) begin
						sda_low <= 1'b0;
						state <= SP_COUNT2;
					end
				SP_COUNT2:
					if (count_done)
						state <= ST_IDLE;
				default: begin
					state <= ST_IDLE;
					sda_low <= 1'b0;
					scl_low <= 1'b0;
				end
			endcase
		end
	end

	// ============================================================
	// Outputs
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_sda_oe <= 1'b0;
			o_scl_oe <= 1'b0;
			o_sda <= 1'b0;
			o_scl <= 1'b0;
		end else begin
			o_sda_oe <= sda_low && !collision;
			o_scl_oe <= scl_low && !collision;
			o_sda <= 1'b0;
			o_scl <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_bus_collision_flag <= 1'b0;
		end else if (collision) begin
			o_bus_collision_flag <= 1'b1;
		end else if (i_clear_bus_collision_flag) begin
			o_bus_collision_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_master_sequence_control <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_busy <= (state != ST_IDLE) && !collision;
			o_done <= !collision && count_done &&
				((state == RS_COUNT3) || (state == SP_COUNT2));
			o_master_sequence_control.restart_enable <= !collision &&
				(state inside {RS_SDA_WAIT, RS_COUNT1, RS_SCL_WAIT, RS_COUNT2, RS_COUNT3}) &&
				!((state == RS_COUNT3) && count_done);
			o_master_sequence_control.stop_enable <= !collision &&
				(state inside {SP_SDA_WAIT, SP_SCL_WAIT, SP_COUNT1, SP_COUNT2}) &&
				!((state == SP_COUNT2) && count_done);
		end
	end

endmodule // i2c_master_collision_detect

// ### verif/i2c_bus_model.sv
`timescale 1ns/1ns
module i2c_bus_model (
	input  wire logic                    i_sda_oe,
	input  wire logic                    i_scl_oe,
	input  wire logic                    i_sda_hold,
	input  wire logic                    i_scl_hold,
	output i2c_collision_pkg::bus_lines_t o_bus
);
	// ======
	// Wired-AND with pull-ups
	assign o_bus = {!(i_sda_oe || i_sda_hold), !(i_scl_oe || i_scl_hold)};
endmodule // i2c_bus_model

// ### verif/i2c_collision_asserts.sv
`timescale 1ns/1ns
module i2c_collision_asserts (
	input wire logic                                        i_clock,
	input wire logic                                        i_rst,
	input wire logic                                        i_clear_bus_collision_flag,
	input wire i2c_collision_pkg::bus_lines_t               i_bus,
	input wire logic                                        o_sda_oe,
	input wire logic                                        o_scl_oe,
	input wire logic                                        o_sda,
	input wire logic                                        o_scl,
	input wire i2c_collision_pkg::master_sequence_control_t o_master_sequence_control,
	input wire logic                                        o_bus_collision_flag,
	input wire logic                                        o_busy,
	input wire logic                                        o_done
);
	// ======
	// Checks
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence scl_up_sda_low;
		!o_scl_oe && !o_sda_oe && $rose(i_bus.scl) && !i_bus.sda;
	endsequence
	never_high_a: assert property (!o_sda && !o_scl) else $error("line driven high");
	abort_idle_a: assert property ($rose(o_bus_collision_flag) |-> !o_busy && !o_sda_oe
		&& !o_scl_oe && o_master_sequence_control == 2'b00) else $error("abort not clean");
	flag_sticky_a: assert property (o_bus_collision_flag && !i_clear_bus_collision_flag
		|=> o_bus_collision_flag) else $error("flag lost");
	done_pulse_a: assert property (o_done |=> !o_done) else $error("done too long");
	start_shape_a: assert property ($rose(o_busy) |-> (o_master_sequence_control.restart_enable
		? (o_scl_oe && !o_sda_oe) : (o_scl_oe && o_sda_oe))) else $error("bad start");
	scl_stretch_a: assert property (o_busy && !o_scl_oe && !i_bus.scl
		&& (o_master_sequence_control.stop_enable || !o_sda_oe) |=> !o_scl_oe)
		else $error("scl taken while held");
	restart_low_a: assert property (o_master_sequence_control.restart_enable
		##0 scl_up_sda_low |-> ##[1:3] o_bus_collision_flag) else $error("missed collision");
	idle_quiet_a: assert property (!o_busy && !$past(o_busy)
		|-> $stable(o_sda_oe) && $stable(o_scl_oe)) else $error("idle drive changed");
endmodule // i2c_collision_asserts
bind i2c_master_collision_detect i2c_collision_asserts chk_u (.i_clock, .i_rst,
	.i_clear_bus_collision_flag, .i_bus, .o_sda_oe, .o_scl_oe, .o_sda, .o_scl,
	.o_master_sequence_control, .o_bus_collision_flag, .o_busy, .o_done);

// ### verif/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
	logic clock = 0, rst = 1, clr = 0, hsda = 0, hscl = 0, flag_d = 0;
	logic sda_oe, scl_oe, sda, scl, flag, busy, done;
	logic [6:0] reload = 7'h20;
	logic [1:0] exp_code;
	logic [1:0] notes[$];
	i2c_collision_pkg::master_sequence_control_t req = '0, seq;
	i2c_collision_pkg::bus_lines_t               bus;
	int num_errors = 0, total_checks = 0, cycles = 0;
	int modes[6] = '{0, 1, 2, 0, 3, 4};
	always #5 clock = ~clock;
	i2c_master_collision_detect dut_u (.i_clock(clock), .i_rst(rst),
		.i_bit_rate_reload_value(reload), .i_master_sequence_control(req),
		.i_clear_bus_collision_flag(clr), .i_bus(bus), .o_sda_oe(sda_oe), .o_scl_oe(scl_oe),
		.o_sda(sda), .o_scl(scl), .o_master_sequence_control(seq),
		.o_bus_collision_flag(flag), .o_busy(busy), .o_done(done));
	i2c_bus_model bus_u (.i_sda_oe(sda_oe), .i_scl_oe(scl_oe), .i_sda_hold(hsda),
		.i_scl_hold(hscl), .o_bus(bus));
	task automatic wrap_up();
		if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ======
	// Outcome watcher and timeout
	always @(posedge clock) begin
		flag_d <= flag;
		cycles++;
		if (done || (flag && !flag_d)) begin
			exp_code = notes.pop_front();
			`CHK("outcome", exp_code, {flag, done})
		end
		if (cycles > 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ======
	// One sequence with optional interference by another master
	task automatic run(input logic rs, input int mode);
		notes.push_back(mode inside {1, 2, 3} ? 2'b10 : 2'b01);
		reload <= 7'h20 | 7'($urandom & 32'h0000_001f);
		req <= rs ? 2'b10 : 2'b01;
		hscl <= (mode == 4);
		@(posedge clock);
		while (!busy) @(posedge clock);
		req <= '0;
		if (mode == 1) repeat (2) @(posedge clock);
		if (mode == 2) while (scl_oe) @(posedge clock);
		if (mode == 2) repeat (3) @(posedge clock);
		if (mode == 3) while (sda_oe) @(posedge clock);
		if (mode == 4) repeat (20) @(posedge clock);
		hsda <= (mode == 1 || mode == 3);
		hscl <= (mode == 2);
		while (busy) @(posedge clock);
		hsda <= 0;
		hscl <= 0;
		`CHK("seq", 2'b00, seq)
		`CHK("oe", (rs && mode == 0) ? 2'b11 : 2'b00, {sda_oe, scl_oe})
		clr <= 1;
		@(posedge clock);
		clr <= 0;
		repeat (2) @(posedge clock);
		`CHK("flag", 1'b0, flag)
	endtask
	initial begin
		void'($urandom(32'h7838_2270));
		repeat (6) @(posedge clock);
		rst <= 0;
		for (int i = 0; i < 12; i++) run((i % 6) < 3, modes[i % 6]);
		wrap_up();
	end
endmodule // testbench
